// File: verilog/pwc_regs.svh
// register map, field positions, reset values and divider table
// assumes byte addressing on a 32-bit apb, one word per register
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH
`define PWC_OFF_CTRL      8'h00
`define PWC_OFF_MOD       8'h04
`define PWC_OFF_COUNT     8'h08
`define PWC_OFF_STATUS    8'h0C
`define PWC_OFF_MASK      8'h10
`define PWC_OFF_CONFIG    8'h14
`define PWC_CTRL_FLAG     7
`define PWC_CTRL_SEL_HI   6
`define PWC_CTRL_SEL_LO   5
`define PWC_CTRL_IE       4
`define PWC_CTRL_PS_HI    3
`define PWC_CTRL_PS_LO    0
`define PWC_CTRL_RST      8'h00
`define PWC_MOD_RST       8'h00
`define PWC_MASK_RST      1'h1
`define PWC_CFG_RST       1'h0
`define PWC_PS_OFF        4'h0
`define PWC_CTRL_LOWPWR_DIV10 8'h1B
`define PWC_PS_TABLE_LO { \
    17'h003E8, 17'h001F4, 17'h00064, 17'h00010, \
    17'h0000A, 17'h00004, 17'h00002, 17'h00001, \
    17'h00400, 17'h00200, 17'h00100, 17'h00080, \
    17'h00040, 17'h00020, 17'h00008, 17'h00000}
`define PWC_PS_TABLE_HI { \
    17'h186A0, 17'h0C350, 17'h09C40, 17'h04E20, \
    17'h02710, 17'h01388, 17'h007D0, 17'h003E8, \
    17'h10000, 17'h08000, 17'h04000, 17'h02000, \
    17'h01000, 17'h00800, 17'h00400, 17'h00000}
`endif

// File: verilog/pwc_pkg.sv
// types shared by the wakeup counter modules
// assumes nothing of its surroundings
package pwc_pkg;
    typedef enum logic [1:0] {
        PWC_SRC_LOWPWR, PWC_SRC_XTAL, PWC_SRC_INT, PWC_SRC_INT2
    } pwc_src_type;
    typedef logic [15:0][16:0] pwc_table_type;
    typedef struct packed {
        logic        prev;
        logic [16:0] pcnt;
        logic        tick;
    } pwc_pre_type;
    typedef struct packed {
        logic [7:0] count;
        logic       event_p;
    } pwc_cnt_type;
    typedef struct packed {
        logic [3:0]  ps_code;
        pwc_src_type sel;
        logic        ie;
        logic        flag;
        logic [7:0]  modulo;
        logic        mask;
        logic        stop_en;
        logic        reload;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
        logic        adc_trig;
    } pwc_top_type;
endpackage : pwc_pkg

// File: verilog/pwc_tick_if.sv
// carrier between control, prescaler and period counter
// assumes all three sit on the same clock
`timescale 1ns/10ps
interface pwc_tick_if;
    pwc_pkg::pwc_src_type clk_sel;
    logic [3:0]           ps_code;
    logic                 sync_clear;
    logic                 run;
    logic                 tick;
    logic [7:0]           modulo;
    logic [7:0]           count;
    logic                 period_event;
    modport ctl (output clk_sel, ps_code, sync_clear, run, modulo,
                 input tick, count, period_event);
    modport pre (input clk_sel, ps_code, sync_clear, run,
                 output tick);
    modport cnt (input tick, modulo, sync_clear,
                 output count, period_event);
endinterface : pwc_tick_if

// File: verilog/pwc_prescaler.sv
// source select and prescaler producing one tick per divided period
// assumes source inputs are synchronous levels, much slower than clock
`include "pwc_regs.svh"
`timescale 1ns/10ps
module pwc_prescaler (
    input  wire logic i_clock,
    input  wire logic i_reset,
    input  wire logic i_src_lowpwr,
    input  wire logic i_src_xtal,
    input  wire logic i_src_int,
    pwc_tick_if.pre   tk
);
    localparam pwc_pkg::pwc_table_type TAB_LO = `PWC_PS_TABLE_LO;
    localparam pwc_pkg::pwc_table_type TAB_HI = `PWC_PS_TABLE_HI;
    pwc_pkg::pwc_pre_type s_r;
    pwc_pkg::pwc_pre_type s_nxt;
    logic                 src;
    logic                 edge_s;
    logic [16:0]          ratio;

    // selected source and its divider ratio
    always_comb begin
        unique case (tk.clk_sel)
            pwc_pkg::PWC_SRC_LOWPWR: src = i_src_lowpwr;
            pwc_pkg::PWC_SRC_XTAL:   src = i_src_xtal;
            pwc_pkg::PWC_SRC_INT,
            pwc_pkg::PWC_SRC_INT2:   src = i_src_int;
        endcase
        ratio = tk.clk_sel[0] ? TAB_HI[tk.ps_code]
                              : TAB_LO[tk.ps_code];
        edge_s = src & ~s_r.prev;
        s_nxt = s_r;
        s_nxt.prev = src;
        s_nxt.tick = 1'b0;
        if (tk.sync_clear) begin
            s_nxt.pcnt = 17'h00000;
        end else if (tk.run && edge_s) begin
            if (s_r.pcnt == ratio - 17'h00001) begin
                s_nxt.pcnt = 17'h00000;
                s_nxt.tick = 1'b1;
            end else begin
                s_nxt.pcnt = s_r.pcnt + 17'h00001;
            end
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign tk.tick = s_r.tick;

    stop_hold_a: assert property (@(posedge i_clock) disable iff (i_reset)
        !tk.run && !tk.sync_clear |=> $stable(s_r.pcnt) && !tk.tick)
        else $error("prescaler moved while halted");
endmodule : pwc_prescaler

// File: verilog/pwc_counter.sv
// 8-bit period counter compared against the modulo value
// assumes one tick pulse per prescaled period
`timescale 1ns/10ps
module pwc_counter (
    input  wire logic i_clock,
    input  wire logic i_reset,
    pwc_tick_if.cnt   tk
);
    pwc_pkg::pwc_cnt_type s_r;
    pwc_pkg::pwc_cnt_type s_nxt;

    // count ticks, wrap at the modulo value
    always_comb begin
        s_nxt = s_r;
        s_nxt.event_p = 1'b0;
        if (tk.sync_clear) begin
            s_nxt.count = 8'h00;
        end else if (tk.tick) begin
            if (s_r.count == tk.modulo) begin
                s_nxt.count   = 8'h00;
                s_nxt.event_p = 1'b1;
            end else begin
                s_nxt.count = s_r.count + 8'h01;
            end
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign tk.count        = s_r.count;
    assign tk.period_event = s_r.event_p;

    period_wrap_a: assert property (@(posedge i_clock) disable iff (i_reset)
        tk.tick && !tk.sync_clear && tk.count == tk.modulo
        |=> tk.period_event && tk.count == 8'h00)
        else $error("no wrap at modulo match");
    count_step_a: assert property (@(posedge i_clock) disable iff (i_reset)
        tk.tick && !tk.sync_clear && tk.count != tk.modulo
        |=> tk.count == $past(tk.count) + 8'h01 && !tk.period_event)
        else $error("count did not step by one");
endmodule : pwc_counter

// File: verilog/pwc_top.sv
// periodic wakeup counter: apb registers, interrupt, conversion trigger
// assumes apb master on I_CLOCK, source inputs synchronous to it
//
// The implementer's own choices: register access over APB and the register addresses.
`include "pwc_regs.svh"
`timescale 1ns/10ps
module pwc_top (
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESET,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_SRC_LOWPWR,
    input  wire logic        I_SRC_XTAL,
    input  wire logic        I_SRC_INT,
    input  wire logic        I_STOP_MODE,
    output logic             O_IRQ,
    output logic             O_ADC_TRIGGER
);

    ////////////////////////////////////////////////////////////////////
    // state and bus decode

    pwc_pkg::pwc_top_type s_r;
    pwc_pkg::pwc_top_type s_nxt;
    logic                 setup;
    logic                 acc_wr;
    logic                 wr_ctrl;
    logic                 wr_mod;
    logic                 wr_status;
    logic                 wr_mask;
    logic                 wr_config;
    logic                 flag_clr;
    logic [7:0]           ctrl_view;
    logic [31:0]          rd_data;
    logic                 rd_err;

    pwc_tick_if tk ();

    // apb phases: data latched in setup, write done in access
    assign setup   = I_PSEL & ~I_PENABLE;
    assign acc_wr  = I_PSEL & I_PENABLE & s_r.pready & I_PWRITE;
    assign wr_ctrl   = acc_wr & (I_PADDR == `PWC_OFF_CTRL);
    assign wr_mod    = acc_wr & (I_PADDR == `PWC_OFF_MOD);
    assign wr_status = acc_wr & (I_PADDR == `PWC_OFF_STATUS);
    assign wr_mask   = acc_wr & (I_PADDR == `PWC_OFF_MASK);
    assign wr_config = acc_wr & (I_PADDR == `PWC_OFF_CONFIG);

    // one-to-clear from either the control or the status word
    assign flag_clr = (wr_ctrl & I_PWDATA[`PWC_CTRL_FLAG])
                    | (wr_status & I_PWDATA[0]);

    // control word as software sees it
    assign ctrl_view = {s_r.flag, s_r.sel, s_r.ie, s_r.ps_code};

    ////////////////////////////////////////////////////////////////////
    // read multiplexer

    // unmapped addresses read zero and flag an error
    always_comb begin
        rd_data = 32'h00000000;
        rd_err  = 1'b0;
        case (I_PADDR)
            `PWC_OFF_CTRL: begin
                rd_data = {24'h000000, ctrl_view};
            end
            `PWC_OFF_MOD: begin
                rd_data = {24'h000000, s_r.modulo};
            end
            `PWC_OFF_COUNT: begin
                rd_data = {24'h000000, tk.count};
            end
            `PWC_OFF_STATUS: begin
                rd_data = {31'h00000000, s_r.flag};
            end
            `PWC_OFF_MASK: begin
                rd_data = {31'h00000000, s_r.mask};
            end
            `PWC_OFF_CONFIG: begin
                rd_data = {31'h00000000, s_r.stop_en};
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    // register writes, flag, interrupt and trigger
    always_comb begin
        s_nxt = s_r;
        s_nxt.reload   = 1'b0;
        s_nxt.adc_trig = 1'b0;
        s_nxt.pslverr  = 1'b0;
        // bus answer: ready one cycle after setup
        s_nxt.pready = setup;
        if (setup) begin
            s_nxt.prdata  = I_PWRITE ? 32'h00000000 : rd_data;
            s_nxt.pslverr = rd_err;
        end else begin
            s_nxt.prdata = 32'h00000000;
        end
        // control word: source, enable, prescaler code
        if (wr_ctrl) begin
            s_nxt.sel = pwc_pkg::pwc_src_type'(
                I_PWDATA[`PWC_CTRL_SEL_HI:`PWC_CTRL_SEL_LO]);
            s_nxt.ie      = I_PWDATA[`PWC_CTRL_IE];
            s_nxt.ps_code = I_PWDATA[`PWC_CTRL_PS_HI:`PWC_CTRL_PS_LO];
            // a new source, enable or ratio restarts the period
            if (I_PWDATA[`PWC_CTRL_SEL_HI:`PWC_CTRL_PS_LO]
                    != {s_r.sel, s_r.ie, s_r.ps_code}) begin
                s_nxt.reload = 1'b1;
            end
        end
        // modulo write restarts the period from zero
        if (wr_mod) begin
            s_nxt.modulo = I_PWDATA[7:0];
            s_nxt.reload = 1'b1;
        end
        if (wr_mask) begin
            s_nxt.mask = I_PWDATA[0];
        end
        if (wr_config) begin
            s_nxt.stop_en = I_PWDATA[0];
        end
        // sticky flag: a new event beats a clear in the same cycle
        if (tk.period_event) begin
            s_nxt.flag = 1'b1;
        end else if (flag_clr) begin
            s_nxt.flag = 1'b0;
        end
        // conversion start follows each period end
        s_nxt.adc_trig = tk.period_event;
        // level interrupt while flag, enable and mask all set
        s_nxt.irq = s_nxt.flag & s_nxt.ie & s_nxt.mask;
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    // synchronous reset to the register defaults
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            s_r         <= '0;
            s_r.ps_code <= 4'(`PWC_CTRL_RST);
            s_r.modulo  <= `PWC_MOD_RST;
            s_r.mask    <= `PWC_MASK_RST;
            s_r.stop_en <= `PWC_CFG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs and carrier

    // every output straight from the state register
    assign O_PRDATA      = s_r.prdata;
    assign O_PREADY      = s_r.pready;
    assign O_PSLVERR     = s_r.pslverr;
    assign O_IRQ         = s_r.irq;
    assign O_ADC_TRIGGER = s_r.adc_trig;

    // settings toward prescaler and counter
    assign tk.clk_sel = s_r.sel;
    assign tk.ps_code = s_r.ps_code;
    assign tk.modulo  = s_r.modulo;
    assign tk.sync_clear = s_r.reload
                         | (s_r.ps_code == `PWC_PS_OFF);
    // halted only in stop mode without stop running enabled
    assign tk.run = ~I_STOP_MODE | s_r.stop_en;

    ////////////////////////////////////////////////////////////////////
    // submodules

    // source select and prescaler
    pwc_prescaler pwc_prescaler_i (
        .i_clock      (I_CLOCK),
        .i_reset      (I_RESET),
        .i_src_lowpwr (I_SRC_LOWPWR),
        .i_src_xtal   (I_SRC_XTAL),
        .i_src_int    (I_SRC_INT),
        .tk           (tk.pre)
    );

    // modulo period counter
    pwc_counter pwc_counter_i (
        .i_clock (I_CLOCK),
        .i_reset (I_RESET),
        .tk      (tk.cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RESET);

    // bus phases
    sequence apb_setup_s;
        I_PSEL && !I_PENABLE;
    endsequence
    sequence apb_access_s;
        I_PSEL && I_PENABLE && O_PREADY;
    endsequence

    // period end and its consequences
    sequence period_end_s;
        tk.period_event && !$past(tk.sync_clear);
    endsequence

    apb_ready_a: assert property (apb_setup_s |=> O_PREADY)
        else $error("no ready after setup");
    apb_single_a: assert property (apb_access_s |=> !O_PREADY)
        else $error("ready held past access");
    flag_set_a: assert property (
        tk.period_event |=> s_r.flag)
        else $error("period end did not set flag");
    flag_clear_a: assert property (
        flag_clr && !tk.period_event |=> !s_r.flag)
        else $error("one write did not clear flag");
    flag_keep_a: assert property (
        wr_ctrl && !I_PWDATA[`PWC_CTRL_FLAG] && s_r.flag
        && !wr_status |=> s_r.flag)
        else $error("zero write cleared flag");
    irq_period_a: assert property (
        period_end_s ##0 (s_r.ie && s_r.mask && !wr_ctrl && !wr_mask)
        |=> O_IRQ)
        else $error("enabled period end gave no interrupt");
    irq_off_a: assert property (
        !s_r.ie |-> !O_IRQ)
        else $error("interrupt while disabled");
    ctrl_example_a: assert property (
        wr_ctrl && I_PWDATA[7:0] == `PWC_CTRL_LOWPWR_DIV10
        |=> s_r.sel == pwc_pkg::PWC_SRC_LOWPWR && s_r.ie
        && s_r.ps_code == 4'hB && tk.clk_sel == pwc_pkg::PWC_SRC_LOWPWR
        ##1 pwc_prescaler_i.ratio == 17'h0000A)
        else $error("example control word misapplied");
    adc_trigger_a: assert property (
        tk.period_event |=> O_ADC_TRIGGER ##1
        (O_ADC_TRIGGER == $past(tk.period_event)))
        else $error("conversion trigger missing");
    off_hold_a: assert property (
        s_r.ps_code == `PWC_PS_OFF |=> tk.count == 8'h00
        && !tk.period_event && !tk.tick)
        else $error("counter moved with prescaler off");
    stop_keeps_a: assert property (
        I_STOP_MODE && s_r.stop_en |-> tk.run)
        else $error("stop mode halted enabled counter");

    // bus answer shape: data and error only with ready
    rdata_idle_a: assert property (
        !O_PREADY |-> O_PRDATA == 32'h00000000)
        else $error("read data outside ready cycle");
    ready_err_a: assert property (
        O_PSLVERR |-> O_PREADY)
        else $error("error without ready");

    // modulo write lands and restarts the period
    mod_write_a: assert property (
        wr_mod |=> s_r.modulo == $past(I_PWDATA[7:0])
        && tk.sync_clear)
        else $error("modulo write not applied");
    reload_clear_a: assert property (
        s_r.reload |=> tk.count == 8'h00 && !tk.period_event
        && !tk.tick)
        else $error("restart did not zero the count");

    // trigger is a single pulse per period end
    trigger_pulse_a: assert property (
        O_ADC_TRIGGER |=> !O_ADC_TRIGGER)
        else $error("conversion trigger held high");

    // set beats clear, and clearing drops the interrupt
    flag_race_a: assert property (
        tk.period_event && flag_clr |=> s_r.flag)
        else $error("clear beat a period end");
    irq_drop_a: assert property (
        flag_clr && !tk.period_event |=> !O_IRQ)
        else $error("interrupt stayed after clear");
    irq_mask_a: assert property (
        !s_r.mask |-> !O_IRQ)
        else $error("interrupt while masked");

endmodule : pwc_top

// File: sim/pwc_top_tb_top.sv
// self-checking bench for the periodic wakeup counter top
// assumes pwc_top with an apb slave and the register map header
`include "pwc_regs.svh"
`timescale 1ns/10ps
module pwc_top_tb_top;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  src;
    logic        stop;
    logic        irq;
    logic        trig;
    int          errors;
    int          checked;
    int          trig_cnt;
    int          t0;
    int          ratio [4] = '{1, 2, 4, 10};

    ////////////////////////////////////////////////////////////////////////
    // device under test, sources packed as {int, xtal, low power}
    pwc_top pwc_top_i (
        .I_CLOCK       (clk),
        .I_RESET       (rst),
        .I_PSEL        (psel),
        .I_PENABLE     (penable),
        .I_PWRITE      (pwrite),
        .I_PADDR       (paddr),
        .I_PWDATA      (pwdata),
        .O_PRDATA      (prdata),
        .O_PREADY      (pready),
        .O_PSLVERR     (pslverr),
        .I_SRC_LOWPWR  (src[0]),
        .I_SRC_XTAL    (src[1]),
        .I_SRC_INT     (src[2]),
        .I_STOP_MODE   (stop),
        .O_IRQ         (irq),
        .O_ADC_TRIGGER (trig)
    );

    // 50 mhz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // conversion trigger pulses seen so far
    always @(posedge clk) begin
        if (trig === 1'b1) trig_cnt <= trig_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // compare and report tasks
    task summarize;
        $display("counts checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    task chk_cnt(input int got, input int exp);
        checked++;
        if (got != exp) begin
            errors++;
            $display("FAIL %0t count got %0d exp %0d", $time, got, exp);
        end
    endtask : chk_cnt

    task test_end(input string name);
        $display("test %s done, errors %0d", name, errors);
    endtask : test_end

    ////////////////////////////////////////////////////////////////////////
    // apb master: setup, access held until pready sampled high
    task apb_xfer(input logic wr, input logic [7:0] addr,
                  input logic [31:0] wdata, input logic exp_err,
                  output logic [31:0] rdata);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            $display("FAIL %0t apb answer timed out", $time);
            summarize();
        end else begin
            rdata = prdata;
            chk_bit(pslverr, exp_err);
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb_xfer

    task apb_wr(input logic [7:0] addr, input logic [31:0] data,
                input logic exp_err);
        logic [31:0] d;
        apb_xfer(1'b1, addr, data, exp_err, d);
    endtask : apb_wr

    task apb_rd(input logic [7:0] addr, input logic [31:0] exp,
                input logic exp_err);
        logic [31:0] d;
        apb_xfer(1'b0, addr, 32'h0, exp_err, d);
        chk_word(d, exp);
    endtask : apb_rd

    // source clocks: high one cycle, low one cycle, then settle
    task pulses(input logic [2:0] which, input int n);
        t0 = trig_cnt;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            src <= which;
            @(posedge clk);
            src <= 3'h0;
        end
        repeat (6) @(posedge clk);
    endtask : pulses

    // interrupt level after a write has landed
    task chk_irq(input logic exp);
        repeat (2) @(posedge clk);
        chk_bit(irq, exp);
    endtask : chk_irq

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        src = 3'h0;
        stop = 1'b0;
        errors = 0;
        checked = 0;
        trig_cnt = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped place, read-only count
        apb_rd(`PWC_OFF_CTRL, 32'h00, 1'b0);
        apb_rd(`PWC_OFF_MOD, 32'h00, 1'b0);
        apb_rd(`PWC_OFF_COUNT, 32'h00, 1'b0);
        apb_rd(`PWC_OFF_STATUS, 32'h00, 1'b0);
        apb_rd(`PWC_OFF_MASK, 32'h01, 1'b0);
        apb_rd(`PWC_OFF_CONFIG, 32'h00, 1'b0);
        apb_wr(8'h18, 32'hFF, 1'b1);
        apb_rd(8'h18, 32'h00, 1'b1);
        apb_wr(`PWC_OFF_COUNT, 32'h55, 1'b0);
        apb_rd(`PWC_OFF_COUNT, 32'h00, 1'b0);
        test_end("reset");
        // modulo 2, low power source, divide by one
        apb_wr(`PWC_OFF_MOD, 32'h02, 1'b0);
        apb_wr(`PWC_OFF_CTRL, 32'h18, 1'b0);
        pulses(3'h1, 2);
        apb_rd(`PWC_OFF_COUNT, 32'h02, 1'b0);
        chk_cnt(trig_cnt - t0, 0);
        pulses(3'h1, 1);
        chk_cnt(trig_cnt - t0, 1);
        apb_rd(`PWC_OFF_COUNT, 32'h00, 1'b0);
        chk_bit(irq, 1'b1);
        pulses(3'h1, 6);
        chk_cnt(trig_cnt - t0, 2);
        pulses(3'h6, 5);
        chk_cnt(trig_cnt - t0, 0);
        test_end("period");
        // flag write one to clear, mask gating
        apb_rd(`PWC_OFF_CTRL, 32'h98, 1'b0);
        apb_wr(`PWC_OFF_CTRL, 32'h18, 1'b0);
        apb_rd(`PWC_OFF_CTRL, 32'h98, 1'b0);
        chk_irq(1'b1);
        apb_wr(`PWC_OFF_MASK, 32'h00, 1'b0);
        chk_irq(1'b0);
        apb_rd(`PWC_OFF_STATUS, 32'h01, 1'b0);
        apb_wr(`PWC_OFF_MASK, 32'h01, 1'b0);
        chk_irq(1'b1);
        apb_wr(`PWC_OFF_STATUS, 32'h01, 1'b0);
        chk_irq(1'b0);
        apb_rd(`PWC_OFF_CTRL, 32'h18, 1'b0);
        test_end("clear");
        // control 0x1B with modulo 9: one event per 100 source edges
        apb_wr(`PWC_OFF_MOD, 32'h09, 1'b0);
        apb_wr(`PWC_OFF_CTRL, `PWC_CTRL_LOWPWR_DIV10, 1'b0);
        pulses(3'h1, 99);
        chk_cnt(trig_cnt - t0, 0);
        pulses(3'h1, 1);
        chk_cnt(trig_cnt - t0, 1);
        chk_bit(irq, 1'b1);
        apb_wr(`PWC_OFF_CTRL, 32'h9B, 1'b0);
        chk_irq(1'b0);
        test_end("lowpower");
        // divider codes 8 to 11 on the low power source, modulo 0
        apb_wr(`PWC_OFF_MOD, 32'h00, 1'b0);
        for (int c = 0; c < 4; c++) begin
            apb_wr(`PWC_OFF_CTRL, 32'h08 + c, 1'b0);
            pulses(3'h1, 2 * ratio[c] - 1);
            chk_cnt(trig_cnt - t0, 1);
        end
        // internal source under both select codes, crystal by 1000
        apb_wr(`PWC_OFF_CTRL, 32'h48, 1'b0);
        pulses(3'h4, 3);
        chk_cnt(trig_cnt - t0, 3);
        // select code 3 takes the long table: code 8 divides by 1000
        apb_wr(`PWC_OFF_CTRL, 32'h68, 1'b0);
        pulses(3'h3, 1000);
        chk_cnt(trig_cnt - t0, 0);
        pulses(3'h4, 1000);
        chk_cnt(trig_cnt - t0, 1);
        apb_wr(`PWC_OFF_CTRL, 32'h28, 1'b0);
        pulses(3'h2, 999);
        chk_cnt(trig_cnt - t0, 0);
        pulses(3'h2, 1);
        chk_cnt(trig_cnt - t0, 1);
        test_end("sources");
        // stop mode halts unless run in stop is set
        apb_wr(`PWC_OFF_STATUS, 32'h01, 1'b0);
        apb_wr(`PWC_OFF_CTRL, 32'h18, 1'b0);
        stop <= 1'b1;
        pulses(3'h1, 3);
        chk_cnt(trig_cnt - t0, 0);
        apb_wr(`PWC_OFF_CONFIG, 32'h01, 1'b0);
        pulses(3'h1, 3);
        chk_cnt(trig_cnt - t0, 3);
        chk_bit(irq, 1'b1);
        stop <= 1'b0;
        apb_wr(`PWC_OFF_STATUS, 32'h01, 1'b0);
        test_end("stop");
        // prescaler off holds everything at zero
        apb_wr(`PWC_OFF_CTRL, 32'h10, 1'b0);
        pulses(3'h7, 5);
        chk_cnt(trig_cnt - t0, 0);
        apb_rd(`PWC_OFF_COUNT, 32'h00, 1'b0);
        chk_bit(irq, 1'b0);
        test_end("off");
        summarize();
    end
endmodule : pwc_top_tb_top
